/* hdl/mpx_pkg.sv */
// Shared constants and types for the multiply parallel execute unit
`default_nettype none
package mpx_pkg;
    localparam int WORD_W     = 32;
    localparam int EXT_W      = 40;
    localparam int XTRA_W     = EXT_W - WORD_W;
    localparam int EXP_W      = 8;
    localparam int FRAC_W     = 23;
    localparam int EXT_FRAC_W = EXT_W - 1 - EXP_W;
    localparam int GUARD_W    = 9;
    localparam int MAN_W      = FRAC_W + 2 + GUARD_W;
    localparam int LZ_W       = 6;
    localparam int INT_W      = 24;
    localparam int PROD_W     = 48;
    localparam int NREG       = 28;
    localparam int RIDX_W     = 5;
    localparam int NMEM       = 16;
    localparam int MA_W       = 4;
    localparam int ADDR_W     = 12;
    localparam logic [EXP_W-1:0]  F_BIAS  = 8'h7F;
    localparam logic [EXP_W-1:0]  EXP_MAX = 8'hFE;
    localparam logic [WORD_W-1:0] SAT_POS = 32'h7FFFFFFF;
    localparam logic [WORD_W-1:0] SAT_NEG = 32'h80000000;
    // Register map, byte addresses
    localparam logic [ADDR_W-1:0] A_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] A_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] A_INSTR  = 12'h008;
    localparam logic [ADDR_W-1:0] A_INDEX  = 12'h00C;
    localparam int WIN_LSB = 8;
    localparam int WIN_W   = 4;
    localparam int IDX_LSB = 2;
    localparam int IDX_W   = 6;
    localparam logic [WIN_W-1:0] WIN_CSR = 4'h0;
    localparam logic [WIN_W-1:0] WIN_REG = 4'h1;
    localparam logic [WIN_W-1:0] WIN_MEM = 4'h2;
    // Control, index and status fields
    localparam int CTRL_SAT = 0;
    localparam int IR0_LSB  = 0;
    localparam int IR1_LSB  = 4;
    localparam int F_C = 0, F_V = 1, F_Z = 2, F_N = 3, F_UF = 4, F_LV = 5, F_LUF = 6;
    localparam int FLAG_W = 7;
    // Instruction word fields
    localparam int OP_LSB = 29, OP_W = 3;
    localparam int P_LSB = 27, P_W = 2;
    localparam int D1_BIT = 26, D2_BIT = 25;
    localparam int S1_LSB = 22, S2_LSB = 19, RS_W = 3;
    localparam int S3_LSB = 12, S4_LSB = 6, IND_W = 6;
    localparam int DST_LSB = 0;
    localparam int IDST_LSB = 21, ISRC_LSB = 0, ISRC_W = 16;
    typedef enum logic [OP_W-1:0] {
        OP_FSUM = 3'h0, OP_FDIFF = 3'h1, OP_FSTORE = 3'h2, OP_IMUL = 3'h3, OP_FMUL = 3'h4
    } mpx_op_type;
    typedef enum logic [1:0] {DISP_ZERO, DISP_ONE, DISP_IR0, DISP_IR1} mpx_disp_type;
    typedef enum logic [1:0] {SM_REG, SM_DIRECT, SM_INDIRECT, SM_IMM} mpx_srcmode_type;
endpackage : mpx_pkg
`default_nettype wire

/* hdl/mpx_fmul.sv */
// Single-precision multiplier with extended-precision product
`timescale 1ns/1ps
`default_nettype none
module mpx_fmul import mpx_pkg::*; (
    input  wire logic [WORD_W-1:0] a,
    input  wire logic [WORD_W-1:0] b,
    output logic      [EXT_W-1:0]  p,
    output logic                   ovf,
    output logic                   unf
);
    logic [PROD_W-1:0]      m;
    logic signed [EXP_W+1:0] e;
    logic [EXT_FRAC_W-1:0]  frac;
    logic                   zero;
    logic                   s;

    always_comb begin
        s    = a[WORD_W-1] ^ b[WORD_W-1];
        zero = (a[WORD_W-2 -: EXP_W] == '0) || (b[WORD_W-2 -: EXP_W] == '0);
        m    = {1'b1, a[FRAC_W-1:0]} * {1'b1, b[FRAC_W-1:0]};
        e    = $signed({2'b00, a[WORD_W-2 -: EXP_W]}) + $signed({2'b00, b[WORD_W-2 -: EXP_W]})
             - $signed({2'b00, F_BIAS}) + $signed({{(EXP_W+1){1'b0}}, m[PROD_W-1]});
        frac = m[PROD_W-1] ? m[PROD_W-2 -: EXT_FRAC_W] : m[PROD_W-3 -: EXT_FRAC_W];
        ovf  = !zero && (e > $signed({2'b00, EXP_MAX}));
        unf  = !zero && (e < $signed({{(EXP_W+1){1'b0}}, 1'b1}));
        if (zero || unf) begin
            p = '0;
        end else if (ovf) begin
            p = {s, EXP_MAX, {EXT_FRAC_W{1'b1}}};
        end else begin
            p = {s, e[EXP_W-1:0], frac};
        end
    end
endmodule : mpx_fmul
`default_nettype wire

/* hdl/mpx_fadd.sv */
// Single-precision adder and subtractor with extended-precision result
`timescale 1ns/1ps
`default_nettype none
module mpx_fadd import mpx_pkg::*; (
    input  wire logic [WORD_W-1:0] a,
    input  wire logic [WORD_W-1:0] b,
    input  wire logic              sub,
    output logic      [EXT_W-1:0]  r,
    output logic                   ovf,
    output logic                   unf
);
    logic [WORD_W-1:0]       bb, big, sml;
    logic [MAN_W-1:0]        mb, ms, sum, norm;
    logic [LZ_W-1:0]         lz;
    logic signed [EXP_W+1:0] e;
    logic [EXT_FRAC_W-1:0]   frac;

    function automatic logic [MAN_W-1:0] mant(input logic [WORD_W-1:0] x);
        mant = (x[WORD_W-2 -: EXP_W] == '0) ? '0 : {2'b01, x[FRAC_W-1:0], {GUARD_W{1'b0}}};
    endfunction : mant

    always_comb begin
        bb = {b[WORD_W-1] ^ sub, b[WORD_W-2:0]};
        if (a[WORD_W-2:0] >= bb[WORD_W-2:0]) begin
            big = a;
            sml = bb;
        end else begin
            big = bb;
            sml = a;
        end
        mb  = mant(big);
        ms  = mant(sml) >> (big[WORD_W-2 -: EXP_W] - sml[WORD_W-2 -: EXP_W]);
        sum = (big[WORD_W-1] == sml[WORD_W-1]) ? mb + ms : mb - ms;
        lz  = '0;
        for (int i = 0; i < MAN_W - 1; i++) begin
            if (sum[i]) begin
                lz = LZ_W'(MAN_W - 2 - i);
            end
        end
        norm = sum << lz;
        if (sum[MAN_W-1]) begin
            e    = $signed({2'b00, big[WORD_W-2 -: EXP_W]}) + 10'sh001;
            frac = sum[MAN_W-2 -: EXT_FRAC_W];
        end else begin
            e    = $signed({2'b00, big[WORD_W-2 -: EXP_W]}) - $signed({4'h0, lz});
            frac = norm[MAN_W-3 -: EXT_FRAC_W];
        end
        ovf = (sum != '0) && (e > $signed({2'b00, EXP_MAX}));
        unf = (sum != '0) && (e < 10'sh001);
        if (sum == '0 || unf) begin
            r = '0;
        end else if (ovf) begin
            r = {big[WORD_W-1], EXP_MAX, {EXT_FRAC_W{1'b1}}};
        end else begin
            r = {big[WORD_W-1], e[EXP_W-1:0], frac};
        end
    end
endmodule : mpx_fadd
`default_nettype wire

/* hdl/mpx_unit.sv */
// Multiply execute unit with paired add, subtract and store, behind an APB slave
// Behaviour
// - Paired multiply-add computes product and sum together in one execute cycle.
// - Paired forms read all sources at cycle start, write results at its end.
// - Same indirect source and store target: source is read before the write.
// - Routing field 00..11 picks multiplier and adder operands from fields one-four.
// - First target bit picks R0 or R1; second picks R2 or R3.
// - Paired forms take two registers R0-R7 and two indirect sources.
// - Multiply-subtract routes like add; first operand minus second operand.
// - Paired add/subtract: N and Z cleared, C kept, V and UF from float faults.
// - Float multiply faults set sticky overflow and underflow, else they hold.
// - Multiply-with-store multiplies register by memory, stores another register.
// - Store form and integer multiply set N and Z from the result.
// - Float multiply forms ignore the saturate mode.
// - Integer multiply: 24-bit signed operands, 48-bit product, low 32 bits kept.
// - Integer overflow when top 16 product bits differ from result bit 31.
// - Integer source mode: register, direct, indirect or immediate; registers 0-27.
// - Integer multiply: V from overflow, LV set on overflow, UF cleared, STICKY_UNDERFLOW_FLAG and C kept.
// - Integer multiply result depends on saturate mode.
// - Plain float multiply writes an extended-precision product of two singles.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mpx_unit import mpx_pkg::*; (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [WORD_W-1:0] pwdata,
    output logic      [WORD_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   saturate_mode,
    output logic                   busy
);
    logic [EXT_W-1:0]  rf_r [NREG];
    logic [WORD_W-1:0] mem_r [NMEM];
    logic [WORD_W-1:0] instr_r;
    logic [FLAG_W-1:0] flags_r, flags_nxt;
    logic [7:0]        index_r;
    logic              sat_r, busy_r, done_r, err_r;
    logic [WORD_W-1:0] prdata_r, rd_mux;
    logic              access, hit, wr_take;
    mpx_op_type        op;
    logic [WORD_W-1:0] r1, r2, m3, m4, mul_a, mul_b, add_a, add_b, st_word;
    logic [EXT_W-1:0]  fm_p, fa_r;
    logic              fm_ovf, fm_unf, fa_ovf, fa_unf;
    logic [RIDX_W-1:0] idst, d1_sel, d2_sel, s_dst;
    logic [WORD_W-1:0] iw, isrc, ires;
    logic signed [PROD_W-1:0] iprod;
    logic              iovf;
    logic              wa_en, wb_en, mw_en;
    logic [RIDX_W-1:0] wa_idx, wb_idx;
    logic [EXT_W-1:0]  wa_val, wb_val;
    logic [MA_W-1:0]   mw_addr;
    logic              exec_pair, exec_imul;

    function automatic logic [WORD_W-1:0] rd_word(input logic [RIDX_W-1:0] idx);
        rd_word = (idx < RIDX_W'(NREG)) ? rf_r[idx][EXT_W-1 -: WORD_W] : '0;
    endfunction : rd_word

    function automatic logic [MA_W-1:0] ind_addr(input logic [IND_W-1:0] f);
        mpx_disp_type d;
        d = mpx_disp_type'(f[1:0]);
        unique case (d)
            DISP_ZERO: ind_addr = f[IND_W-1 -: MA_W];
            DISP_ONE:  ind_addr = f[IND_W-1 -: MA_W] + MA_W'(1);
            DISP_IR0:  ind_addr = f[IND_W-1 -: MA_W] + index_r[IR0_LSB +: MA_W];
            DISP_IR1:  ind_addr = f[IND_W-1 -: MA_W] + index_r[IR1_LSB +: MA_W];
        endcase
    endfunction : ind_addr

    function automatic logic [RIDX_W-1:0] rs(input int lsb);
        rs = {2'b00, instr_r[lsb +: RS_W]};
    endfunction : rs

    // APB slave: one wait state, longer while an instruction executes
    assign access        = psel & penable;
    assign pready        = access & done_r;
    assign pslverr       = pready & err_r;
    assign prdata        = prdata_r;
    assign wr_take       = pready & pwrite & !err_r;
    assign saturate_mode = sat_r;
    assign busy          = busy_r;

    always_comb begin
        hit    = 1'b1;
        rd_mux = '0;
        unique case (paddr[WIN_LSB +: WIN_W])
            WIN_CSR: begin
                if (paddr == A_CTRL) begin
                    rd_mux[CTRL_SAT] = sat_r;
                end else if (paddr == A_STATUS) begin
                    rd_mux[FLAG_W-1:0] = flags_r;
                end else if (paddr == A_INSTR) begin
                    rd_mux = instr_r;
                end else if (paddr == A_INDEX) begin
                    rd_mux[7:0] = index_r;
                end else begin
                    hit = 1'b0;
                end
            end
            WIN_REG: begin
                hit    = paddr[IDX_LSB +: IDX_W] < IDX_W'(NREG);
                rd_mux = rd_word(paddr[IDX_LSB +: RIDX_W]);
            end
            WIN_MEM: begin
                hit    = paddr[IDX_LSB +: IDX_W] < IDX_W'(NMEM);
                rd_mux = mem_r[paddr[IDX_LSB +: MA_W]];
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            done_r   <= 1'b0;
            err_r    <= 1'b0;
            prdata_r <= '0;
        end else if (pready) begin
            done_r <= 1'b0;
        end else if (access && !busy_r) begin
            // Sampled after execution ends so a read never sees a half-written result
            done_r   <= 1'b1;
            err_r    <= !hit;
            prdata_r <= (pwrite || !hit) ? '0 : rd_mux;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sat_r   <= 1'b0;
            index_r <= '0;
            instr_r <= '0;
            busy_r  <= 1'b0;
        end else begin
            busy_r <= wr_take && paddr == A_INSTR;
            if (wr_take && paddr == A_CTRL) begin
                sat_r <= pwdata[CTRL_SAT];
            end
            if (wr_take && paddr == A_INDEX) begin
                index_r <= pwdata[7:0];
            end
            if (wr_take && paddr == A_INSTR) begin
                instr_r <= pwdata;
            end
        end
    end

    // Execute cycle: every source is read combinationally from the old state
    assign op      = mpx_op_type'(instr_r[OP_LSB +: OP_W]);
    assign d1_sel  = {{(RIDX_W-1){1'b0}}, instr_r[D1_BIT]};
    assign d2_sel  = {{(RIDX_W-2){1'b0}}, 1'b1, instr_r[D2_BIT]};

    // A process, not assigns: the read functions look at state beyond their arguments
    always_comb begin
        r1      = rd_word(rs(S1_LSB));
        r2      = rd_word(rs(S2_LSB));
        m3      = mem_r[ind_addr(instr_r[S3_LSB +: IND_W])];
        m4      = mem_r[ind_addr(instr_r[S4_LSB +: IND_W])];
        st_word = r2;
        s_dst   = rs(DST_LSB);
        iw      = rd_word(idst);
    end

    always_comb begin
        add_a = r1;
        add_b = r2;
        mul_a = m3;
        mul_b = m4;
        if (op == OP_FSTORE) begin
            mul_a = r1;
            mul_b = m3;
        end else if (op == OP_FMUL) begin
            mul_a = r1;
            mul_b = r2;
        end else begin
            unique case (instr_r[P_LSB +: P_W])
                2'b00: begin
                    mul_a = m3; mul_b = m4; add_a = r1; add_b = r2;
                end
                2'b01: begin
                    mul_a = m3; mul_b = r1; add_a = m4; add_b = r2;
                end
                2'b10: begin
                    mul_a = r1; mul_b = r2; add_a = m3; add_b = m4;
                end
                2'b11: begin
                    mul_a = m3; mul_b = r1; add_a = r2; add_b = m4;
                end
            endcase
        end
    end

    // Both halves are combinational, so both finish in the one execute cycle
    mpx_fmul u_fmul (
        .a   (mul_a),
        .b   (mul_b),
        .p   (fm_p),
        .ovf (fm_ovf),
        .unf (fm_unf)
    );

    mpx_fadd u_fadd (
        .a   (add_a),
        .b   (add_b),
        .sub (op == OP_FDIFF),
        .r   (fa_r),
        .ovf (fa_ovf),
        .unf (fa_unf)
    );

    // Integer multiply path; low 24 bits of each word are the operands
    assign idst = instr_r[IDST_LSB +: RIDX_W];

    always_comb begin
        unique case (mpx_srcmode_type'(instr_r[P_LSB +: P_W]))
            SM_REG:      isrc = rd_word(instr_r[ISRC_LSB +: RIDX_W]);
            SM_DIRECT:   isrc = mem_r[instr_r[ISRC_LSB +: MA_W]];
            SM_INDIRECT: isrc = mem_r[ind_addr(instr_r[ISRC_LSB +: IND_W])];
            SM_IMM:      isrc = {{(WORD_W-ISRC_W){instr_r[ISRC_W-1]}}, instr_r[ISRC_W-1:0]};
        endcase
        iprod = $signed(iw[INT_W-1:0]) * $signed(isrc[INT_W-1:0]);
        iovf  = iprod[PROD_W-1:WORD_W] != {(PROD_W-WORD_W){iprod[WORD_W-1]}};
        ires  = iprod[WORD_W-1:0];
        if (sat_r && iovf) begin
            ires = iprod[PROD_W-1] ? SAT_NEG : SAT_POS;
        end
    end

    // Result routing and flags; the float paths never look at the saturate mode
    always_comb begin
        wa_en     = 1'b0;
        wb_en     = 1'b0;
        mw_en     = 1'b0;
        wa_idx    = s_dst;
        wb_idx    = d2_sel;
        wa_val    = fm_p;
        wb_val    = fa_r;
        mw_addr   = ind_addr(instr_r[S4_LSB +: IND_W]);
        flags_nxt = flags_r;
        if (busy_r) begin
            unique case (op)
                OP_FSUM, OP_FDIFF: begin
                    wa_en            = 1'b1;
                    wb_en            = 1'b1;
                    wa_idx           = d1_sel;
                    flags_nxt[F_N]   = 1'b0;
                    flags_nxt[F_Z]   = 1'b0;
                    flags_nxt[F_V]   = fm_ovf | fa_ovf;
                    flags_nxt[F_UF]  = fm_unf | fa_unf;
                    flags_nxt[F_LV]  = flags_r[F_LV] | fm_ovf | fa_ovf;
                    flags_nxt[F_LUF] = flags_r[F_LUF] | fm_unf | fa_unf;
                end
                OP_FSTORE, OP_FMUL: begin
                    wa_en            = 1'b1;
                    mw_en            = op == OP_FSTORE;
                    flags_nxt[F_N]   = fm_p[EXT_W-1] && fm_p[EXT_W-2 -: EXP_W] != '0;
                    flags_nxt[F_Z]   = fm_p[EXT_W-2 -: EXP_W] == '0;
                    flags_nxt[F_V]   = fm_ovf;
                    flags_nxt[F_UF]  = fm_unf;
                    flags_nxt[F_LV]  = flags_r[F_LV] | fm_ovf;
                    flags_nxt[F_LUF] = flags_r[F_LUF] | fm_unf;
                end
                OP_IMUL: begin
                    wa_en           = idst < RIDX_W'(NREG);
                    wa_idx          = idst;
                    wa_val          = {ires, {XTRA_W{1'b0}}};
                    flags_nxt[F_N]  = ires[WORD_W-1];
                    flags_nxt[F_Z]  = ires == '0;
                    flags_nxt[F_V]  = iovf;
                    flags_nxt[F_UF] = 1'b0;
                    flags_nxt[F_LV] = flags_r[F_LV] | iovf;
                end
                default: ;
            endcase
        end
    end

    // Writes land at the end of the execute cycle; product is written last so it wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NREG; i++) begin
                rf_r[i] <= '0;
            end
        end else begin
            if (wr_take && paddr[WIN_LSB +: WIN_W] == WIN_REG) begin
                rf_r[paddr[IDX_LSB +: RIDX_W]] <= {pwdata, {XTRA_W{1'b0}}};
            end
            if (wb_en) begin
                rf_r[wb_idx] <= wb_val;
            end
            if (wa_en) begin
                rf_r[wa_idx] <= wa_val;
            end
        end
    end

    // Memory write happens at the edge, after the combinational source read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NMEM; i++) begin
                mem_r[i] <= '0;
            end
        end else if (mw_en) begin
            mem_r[mw_addr] <= st_word;
        end else if (wr_take && paddr[WIN_LSB +: WIN_W] == WIN_MEM) begin
            mem_r[paddr[IDX_LSB +: MA_W]] <= pwdata;
        end
    end

    // Software may write the flags only while nothing executes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags_r <= '0;
        end else if (wr_take && paddr == A_STATUS) begin
            flags_r <= pwdata[FLAG_W-1:0];
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign exec_pair = busy_r && (op == OP_FSUM || op == OP_FDIFF);
    assign exec_imul = busy_r && op == OP_IMUL;

    AST_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy_r |=> !busy_r ##1 !pready || !busy_r)
        else $error("execute lasted more than one cycle");
    AST_PAIR_NZ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exec_pair |=> !flags_r[F_N] && !flags_r[F_Z]
            && flags_r[F_V] == $past(fm_ovf || fa_ovf))
        else $error("paired form flags wrong");
    AST_CARRY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy_r |=> $stable(flags_r[F_C]))
        else $error("carry changed by execute");
    AST_LATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy_r && op inside {OP_FSUM, OP_FDIFF, OP_FSTORE, OP_FMUL} && fm_ovf |=>
            flags_r[F_LV] && flags_r[F_V])
        else $error("float overflow not latched");
    AST_IMUL_FLAGS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exec_imul |=> flags_r[F_V] == $past(iovf) && !flags_r[F_UF]
            && flags_r[F_LUF] == $past(flags_r[F_LUF]))
        else $error("integer multiply flags wrong");
    AST_SAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exec_imul && sat_r && iovf && idst < RIDX_W'(NREG) |=>
            rf_r[$past(idst)][EXT_W-1 -: WORD_W] == ($past(iprod[PROD_W-1]) ? SAT_NEG : SAT_POS))
        else $error("saturated result wrong");
    AST_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exec_imul && !sat_r && idst < RIDX_W'(NREG) |=>
            rf_r[$past(idst)][EXT_W-1 -: WORD_W] == $past(iprod[WORD_W-1:0]))
        else $error("wrapped result wrong");
    AST_D1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exec_pair |=> rf_r[$past(d1_sel)] == $past(fm_p))
        else $error("product not in selected target");
    AST_STORE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy_r && op == OP_FSTORE |=> mem_r[$past(mw_addr)] == $past(st_word))
        else $error("store did not use pre-execute register value");
endmodule : mpx_unit
`default_nettype wire

/* tb/multiply_parallel_exec_unit_tb_top.sv */
// Self-checking bench for the multiply parallel execute unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module multiply_parallel_exec_unit_tb_top import mpx_pkg::*;;
    logic              sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic              pready, pslverr, saturate_mode, busy, e;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [WORD_W-1:0] pwdata = 32'h0, prdata, q;
    int                bad_count = 0, n_checks = 0;
    // Expected product, sum and difference for routing codes 0..3
    logic [31:0] mul_x [4] = '{32'h40800000, 32'h40000000, 32'h40C00000, 32'h40000000};
    logic [31:0] add_x [4] = '{32'h40A00000, 32'h40E00000, 32'h40A00000, 32'h40E00000};
    logic [31:0] sub_x [4] = '{32'hBF800000, 32'h3F800000, 32'hC0400000, 32'hBF800000};
    always #4 sys_clk = ~sys_clk;
    mpx_unit i_mpx_unit (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .saturate_mode(saturate_mode), .busy(busy));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    function automatic logic [11:0] ra(input int n);
        return 12'h100 + 12'(4 * n);
    endfunction : ra
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            $display("[FAIL] %0t bus transfer timed out", $time);
            report_and_stop();
        end
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
    task automatic rc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0); `CHK(q, x)
    endtask : rc
    task automatic exec(input logic [31:0] i);
        wr(A_INSTR, i);
        @(posedge sys_clk); `CHK(busy, 1'b1)
    endtask : exec
    task automatic t_reset;
        rc(A_STATUS, 32'h0); rc(A_CTRL, 32'h0); rc(ra(27), 32'h0);
        apb(1'b0, 12'h300, 32'h0); `CHK({e, q}, 33'h100000000)
        $display("reset test done");
    endtask : t_reset
    task automatic t_fmul;
        // Saturate mode on: float forms must not care
        // The control write lands at the completing edge; look one edge later
        wr(A_CTRL, 32'h1);
        @(posedge sys_clk); `CHK(saturate_mode, 1'b1)
        wr(ra(4), 32'h7F000000); wr(ra(5), 32'h7F000000); wr(A_STATUS, 32'h0);
        exec({3'h4, 4'h0, 3'd4, 3'd5, 16'h0, 3'd7}); rc(A_STATUS, 32'h22);
        wr(ra(4), 32'h40000000); wr(ra(5), 32'h40400000);
        exec({3'h4, 4'h0, 3'd4, 3'd5, 16'h0, 3'd7});
        rc(ra(7), 32'h40C00000); rc(A_STATUS, 32'h20);
        $display("float multiply test done");
    endtask : t_fmul
    task automatic imul(input logic [1:0] m, input logic [4:0] r, input logic [15:0] s,
            input logic [31:0] v, input logic [6:0] p, input logic [31:0] x, input logic [6:0] f);
        wr(ra(r), v); wr(A_STATUS, {25'h0, p});
        exec({3'h3, m, 1'b0, r, 5'h0, s});
        rc(ra(r), x); rc(A_STATUS, {25'h0, f});
    endtask : imul
    task automatic t_int;
        wr(ra(1), 32'h0033C251);
        imul(2'd0, 5'd5, 16'h1, 32'h0078B600, 7'h00, 32'h7FFFFFFF, 7'h22);
        imul(2'd0, 5'd5, 16'h1, 32'hFF874A00, 7'h00, 32'h80000000, 7'h2A);
        wr(A_CTRL, 32'h0);
        imul(2'd0, 5'd5, 16'h1, 32'h0078B600, 7'h51, 32'hE21D9600, 7'h6B);
        imul(2'd3, 5'd2, 16'hFFCE, 32'hC8, 7'h00, 32'hFFFFD8F0, 7'h08);
        wr(ra(200), 32'h0); wr(12'h20C, 32'h0); wr(12'h210, 32'h3); wr(A_INDEX, 32'h1);
        imul(2'd1, 5'd27, 16'h3, 32'hC8, 7'h00, 32'h0, 7'h04);
        imul(2'd2, 5'd6, 16'h0E, 32'hC8, 7'h00, 32'h258, 7'h00);
        $display("integer multiply test done");
    endtask : t_int
    task automatic t_pair;
        wr(12'h200, 32'h3F800000); wr(12'h204, 32'h40800000);
        for (int p = 0; p < 4; p++) begin
            for (int o = 0; o < 2; o++) begin
                wr(ra(0), 32'h40000000); wr(ra(3), 32'h40400000); wr(A_STATUS, 32'h0D);
                exec({3'(o), 2'(p), p[0], p[1], 3'd0, 3'd3, 1'b0, 6'h00, 6'h04, 6'h0});
                rc(ra(p[0]), mul_x[p]);
                rc(ra(2 + p[1]), (o == 1) ? sub_x[p] : add_x[p]);
                rc(A_STATUS, 32'h01);
            end
        end
        $display("paired arithmetic test done");
    endtask : t_pair
    task automatic t_store;
        // Product source and store target are the same word, reached with disp zero and disp one
        wr(ra(6), 32'h40000000); wr(12'h208, 32'h40800000); wr(A_STATUS, 32'h0D);
        exec({3'h2, 4'h0, 3'd6, 3'd6, 1'b0, 6'h08, 6'h05, 3'h0, 3'd6});
        rc(ra(6), 32'h41000000);
        rc(12'h208, 32'h40000000);
        rc(A_STATUS, 32'h01);
        $display("store test done");
    endtask : t_store
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_fmul();
        t_int();
        t_pair();
        t_store();
        report_and_stop();
    end
endmodule : multiply_parallel_exec_unit_tb_top
`default_nettype wire
